/* File: rtl/mcr_meter_top.sv */
// Command interpreter, trigger sequencer and readout of the meter
`default_nettype none

// ----------------------------------------
// Output byte buffer
// ----------------------------------------
module mcr_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	logic push;
	logic pop;
	assign in_ready = cnt_reg != (AW+1)'(DEPTH);
	assign out_valid = cnt_reg != '0;
	assign out_data = mem_reg[rd_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end
	// Depth must be a power of two so the pointers wrap by themselves
	always_ff @(posedge clk)
	begin
		if (!rst_n || flush)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			if (push)
				wr_reg <= wr_reg + 1'b1;
			if (pop)
				rd_reg <= rd_reg + 1'b1;
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ----------------------------------------
// Top
// ----------------------------------------
module mcr_meter_top #(
	parameter int DELAY_AC_CYC = mcr_pkg::DELAY_AC_CYC,
	parameter logic [63:0] OVLD_REAL64 = 64'h0,
	parameter logic [31:0] OVLD_REAL32 = 32'h0,
	parameter int FIFO_DEPTH = mcr_pkg::FIFO_DEPTH
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic mains_50hz,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire mcr_pkg::mcr_cmd_s cmd,
	input wire logic trig_ext,
	output mcr_pkg::mcr_cfg_s cfg,
	output logic ocomp_apply,
	output logic busy,
	output logic meas_start,
	input wire logic meas_done,
	input wire mcr_pkg::mcr_rdg_s rdg,
	output logic out_valid,
	input wire logic out_ready,
	output logic [7:0] out_byte,
	output logic out_eoi,
	output logic mem_wr,
	output logic [31:0] mem_data,
	output logic esr_dev_err,
	input wire logic esr_clear,
	output logic query_err
);
	mcr_pkg::mcr_state_e st_reg;
	mcr_pkg::mcr_cfg_s cfg_reg;
	mcr_pkg::mcr_cfg_s cfg_next;
	mcr_pkg::mcr_cfg_s cfg_use;
	mcr_pkg::mcr_rdg_s rdg_reg;
	logic to_out_reg;
	logic [7:0] trig_left_reg;
	logic [13:0] smp_left_reg;
	logic [26:0] delay_reg;
	logic [3:0] idx_reg;
	logic start_reg;
	logic mem_wr_reg;
	logic err_reg;
	logic qerr_reg;
	logic [31:0] bcd_reg;
	logic [3:0] ndig_reg;
	logic cmd_take;
	logic load;
	logic arm;
	logic bus_trig;
	logic trig_fire;
	logic last_rdg;
	logic rdg_fin;
	logic emit_valid;
	logic emit_take;
	logic emit_eoi;
	logic [7:0] emit_byte;
	logic [7:0] data_byte;
	logic [3:0] nbytes;
	logic [3:0] emit_last;
	logic [3:0] bi;
	logic [2:0] dsel;
	logic [5:0] chans;
	logic [13:0] per_trig;
	logic [24:0] total_bytes;
	logic [31:0] bcd_arm;
	logic [3:0] ndig_arm;
	logic [3:0] lc;
	logic [19:0] base_us;
	logic [26:0] delay_load;
	logic fifo_ready;
	logic fifo_flush;

	function automatic logic [31:0] mcr_to_bcd(input logic [24:0] bin);
		logic [31:0] bcd;
		bcd = '0;
		for (int i = 24; i >= 0; i--)
		begin
			for (int d = 0; d < 8; d++)
				if (bcd[4*d +: 4] > 4'h4)
					bcd[4*d +: 4] = bcd[4*d +: 4] + 4'h3;
			bcd = {bcd[30:0], bin[i]};
		end
		return bcd;
	endfunction

	// ----------------------------------------
	// Command decode and setup loading
	// ----------------------------------------
	assign cmd_ready = (st_reg == mcr_pkg::ST_IDLE) ||
		(st_reg == mcr_pkg::ST_WAIT_TRIG && cmd.op == mcr_pkg::CMD_BUS_TRIG);
	assign cmd_take = cmd_valid && cmd_ready;
	assign load = cmd_take && (cmd.op == mcr_pkg::CMD_MEASURE ||
		cmd.op == mcr_pkg::CMD_CONFIGURE);
	assign arm = cmd_take && (cmd.op == mcr_pkg::CMD_MEASURE ||
		cmd.op == mcr_pkg::CMD_READ || cmd.op == mcr_pkg::CMD_INIT);
	assign bus_trig = cmd_take && cmd.op == mcr_pkg::CMD_BUS_TRIG &&
		st_reg == mcr_pkg::ST_WAIT_TRIG;
	assign base_us = mains_50hz ? mcr_pkg::APER_50HZ_US :
		mcr_pkg::APER_60HZ_US;
	assign lc = !cmd.res_given ? mcr_pkg::LINE_CYC_RST :
		(cmd.res[3:0] == 4'h0 ? 4'h1 : cmd.res[3:0]);

	always_comb
	begin
		cfg_next = mcr_pkg::CFG_RST;
		cfg_next.func = cmd.func;
		cfg_next.range_code = cmd.range_code;
		cfg_next.range_auto = cmd.range_auto;
		cfg_next.res = cmd.res_given ? cmd.res :
			cmd.range_code + {4'h0, lc};
		cfg_next.integration_line_cycles = lc;
		cfg_next.aper_us = 20'(20'(lc) * base_us);
		cfg_next.scanning = cmd.has_chan_list;
		cfg_next.chan_count = cmd.chan_count;
		cfg_next.fmt = cfg_reg.fmt;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			cfg_reg <= mcr_pkg::CFG_RST;
		else if (load)
			cfg_reg <= cfg_next;
		else if (cmd_take && cmd.op == mcr_pkg::CMD_SET)
		begin
			case (cmd.par)
			mcr_pkg::PAR_RANGE:
			begin
				cfg_reg.range_code <= cmd.value[7:0];
				cfg_reg.range_auto <= cmd.value[8];
			end
			mcr_pkg::PAR_RES: cfg_reg.res <= cmd.value[7:0];
			mcr_pkg::PAR_APER: cfg_reg.aper_us <= cmd.value[19:0];
			mcr_pkg::PAR_LINE_CYC:
				cfg_reg.integration_line_cycles <= cmd.value[3:0];
			mcr_pkg::PAR_AUTOZERO: cfg_reg.autozero <= cmd.value[0];
			mcr_pkg::PAR_OFFSET_COMP:
				cfg_reg.offset_compensation_setting <= cmd.value[0];
			mcr_pkg::PAR_TRIG_SRC:
				cfg_reg.trig_src <= mcr_pkg::mcr_src_e'(cmd.value[1:0]);
			mcr_pkg::PAR_TRIG_COUNT: cfg_reg.trig_count <= cmd.value[7:0];
			mcr_pkg::PAR_DELAY:
			begin
				cfg_reg.delay_auto <= cmd.value[27];
				cfg_reg.delay_cyc <= cmd.value[26:0];
			end
			mcr_pkg::PAR_SAMP_COUNT: cfg_reg.samp_count <= cmd.value[7:0];
			mcr_pkg::PAR_FORMAT:
				cfg_reg.fmt <= mcr_pkg::mcr_fmt_e'(cmd.value[1:0]);
			default: cfg_reg <= cfg_reg;
			endcase
		end
	end

	// Offset correction is meaningless outside resistance
	assign ocomp_apply = cfg_reg.offset_compensation_setting &&
		(cfg_reg.func == mcr_pkg::FN_RES ||
		cfg_reg.func == mcr_pkg::FN_FOUR_WIRE_RESISTANCE);

	// ----------------------------------------
	// Reading counts and block header length
	// ----------------------------------------
	assign cfg_use = load ? cfg_next : cfg_reg;
	assign chans = (cfg_use.scanning && cfg_use.chan_count != 6'h00) ?
		cfg_use.chan_count : 6'h01;
	assign per_trig = 14'(cfg_use.samp_count) * 14'(chans);
	assign total_bytes = 25'(25'(cfg_use.trig_count) * 25'(per_trig) *
		25'(cfg_use.fmt == mcr_pkg::FMT_REAL64 ? mcr_pkg::BYTES_REAL64 :
		mcr_pkg::BYTES_REAL32));
	assign bcd_arm = mcr_to_bcd(total_bytes);

	always_comb
	begin
		ndig_arm = 4'h1;
		for (int d = 1; d < 8; d++)
			if (bcd_arm[4*d +: 4] != 4'h0)
				ndig_arm = 4'(d + 1);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			bcd_reg <= '0;
			ndig_reg <= 4'h1;
		end
		else if (arm)
		begin
			bcd_reg <= bcd_arm;
			ndig_reg <= ndig_arm;
		end
	end

	// ----------------------------------------
	// Trigger sequence
	// ----------------------------------------
	assign trig_fire = cfg_reg.trig_src == mcr_pkg::SRC_IMM ||
		(cfg_reg.trig_src == mcr_pkg::SRC_EXT && trig_ext) ||
		(cfg_reg.trig_src == mcr_pkg::SRC_BUS && bus_trig);
	assign delay_load = !cfg_reg.delay_auto ? cfg_reg.delay_cyc :
		(cfg_reg.func == mcr_pkg::FN_ACV ? 27'(DELAY_AC_CYC) :
		27'(mcr_pkg::DELAY_DC_CYC));
	assign last_rdg = smp_left_reg == 14'h1 && trig_left_reg == 8'h01;
	assign rdg_fin = (st_reg == mcr_pkg::ST_SAMPLE && meas_done &&
		!to_out_reg) || (st_reg == mcr_pkg::ST_EMIT && emit_take &&
		idx_reg == emit_last);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_reg <= mcr_pkg::ST_IDLE;
			to_out_reg <= 1'b0;
			trig_left_reg <= '0;
			smp_left_reg <= '0;
			delay_reg <= '0;
			idx_reg <= '0;
			start_reg <= 1'b0;
			mem_wr_reg <= 1'b0;
		end
		else
		begin
			start_reg <= 1'b0;
			mem_wr_reg <= 1'b0;
			case (st_reg)
			mcr_pkg::ST_IDLE:
				if (arm)
				begin
					to_out_reg <= cmd.op != mcr_pkg::CMD_INIT;
					trig_left_reg <= cfg_use.trig_count;
					smp_left_reg <= per_trig;
					idx_reg <= '0;
					st_reg <= (cmd.op != mcr_pkg::CMD_INIT &&
						cfg_use.fmt != mcr_pkg::FMT_ASCII) ?
						mcr_pkg::ST_HEADER : mcr_pkg::ST_WAIT_TRIG;
				end
			mcr_pkg::ST_HEADER:
				if (emit_take && idx_reg == ndig_reg + 4'h1)
				begin
					idx_reg <= '0;
					st_reg <= mcr_pkg::ST_WAIT_TRIG;
				end
				else if (emit_take)
					idx_reg <= idx_reg + 4'h1;
			mcr_pkg::ST_WAIT_TRIG:
				if (trig_fire)
				begin
					delay_reg <= delay_load;
					st_reg <= mcr_pkg::ST_DELAY;
				end
			mcr_pkg::ST_DELAY:
				if (delay_reg == '0)
				begin
					start_reg <= 1'b1;
					st_reg <= mcr_pkg::ST_SAMPLE;
				end
				else
					delay_reg <= delay_reg - 27'h1;
			mcr_pkg::ST_SAMPLE:
				if (meas_done && to_out_reg)
				begin
					idx_reg <= '0;
					st_reg <= mcr_pkg::ST_EMIT;
				end
				else if (meas_done)
					mem_wr_reg <= 1'b1;
			mcr_pkg::ST_EMIT:
				if (emit_take)
					idx_reg <= idx_reg + 4'h1;
			default: st_reg <= mcr_pkg::ST_IDLE;
			endcase
			// Scan restarts at once; a new trigger only after a full pass
			if (rdg_fin)
			begin
				idx_reg <= '0;
				if (smp_left_reg > 14'h1)
				begin
					smp_left_reg <= smp_left_reg - 14'h1;
					start_reg <= 1'b1;
					st_reg <= mcr_pkg::ST_SAMPLE;
				end
				else if (trig_left_reg > 8'h01)
				begin
					trig_left_reg <= trig_left_reg - 8'h01;
					smp_left_reg <= per_trig;
					st_reg <= mcr_pkg::ST_WAIT_TRIG;
				end
				else
					st_reg <= mcr_pkg::ST_IDLE;
			end
		end
	end

	// ----------------------------------------
	// Reading capture and overload
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rdg_reg <= '0;
		else if (st_reg == mcr_pkg::ST_SAMPLE && meas_done)
		begin
			rdg_reg <= rdg;
			if (rdg.overload && cfg_reg.func == mcr_pkg::FN_TEMP)
			begin
				rdg_reg.ascii <= mcr_pkg::ASCII_OVLD;
				rdg_reg.real64 <= OVLD_REAL64;
				rdg_reg.real32 <= OVLD_REAL32;
			end
		end
	end

	// Set beats clear so an overload in the clearing cycle survives
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			err_reg <= 1'b0;
		else if (st_reg == mcr_pkg::ST_SAMPLE && meas_done && rdg.overload)
			err_reg <= 1'b1;
		else if (esr_clear)
			err_reg <= 1'b0;
	end

	// Unread answer is dropped when any command other than a bus trigger comes in
	assign fifo_flush = cmd_take && out_valid &&
		cmd.op != mcr_pkg::CMD_BUS_TRIG;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			qerr_reg <= 1'b0;
		else
			qerr_reg <= fifo_flush;
	end

	// ----------------------------------------
	// Byte framing
	// ----------------------------------------
	assign nbytes = cfg_reg.fmt == mcr_pkg::FMT_ASCII ? mcr_pkg::ASCII_LEN :
		(cfg_reg.fmt == mcr_pkg::FMT_REAL64 ? mcr_pkg::BYTES_REAL64 :
		mcr_pkg::BYTES_REAL32);
	assign emit_last = (cfg_reg.fmt == mcr_pkg::FMT_ASCII || last_rdg) ?
		nbytes : nbytes - 4'h1;
	assign bi = nbytes - 4'h1 - idx_reg;
	assign dsel = 3'(ndig_reg + 4'h1 - idx_reg);
	assign emit_take = emit_valid && fifo_ready;

	always_comb
	begin
		case (cfg_reg.fmt)
		mcr_pkg::FMT_REAL64: data_byte = rdg_reg.real64[8*bi[2:0] +: 8];
		mcr_pkg::FMT_REAL32: data_byte = rdg_reg.real32[8*bi[1:0] +: 8];
		default: data_byte = rdg_reg.ascii[8*bi +: 8];
		endcase
	end

	always_comb
	begin
		emit_valid = 1'b0;
		emit_byte = mcr_pkg::CH_LF;
		emit_eoi = 1'b0;
		if (st_reg == mcr_pkg::ST_HEADER)
		begin
			emit_valid = 1'b1;
			if (idx_reg == 4'h0)
				emit_byte = mcr_pkg::CH_HASH;
			else if (idx_reg == 4'h1)
				emit_byte = mcr_pkg::CH_ZERO + {4'h0, ndig_reg};
			else
				emit_byte = mcr_pkg::CH_ZERO + {4'h0, bcd_reg[4*dsel +: 4]};
		end
		else if (st_reg == mcr_pkg::ST_EMIT)
		begin
			emit_valid = 1'b1;
			if (idx_reg < nbytes)
				emit_byte = data_byte;
			else if (cfg_reg.fmt == mcr_pkg::FMT_ASCII && !last_rdg)
				emit_byte = mcr_pkg::CH_COMMA;
			else
				emit_eoi = 1'b1;
		end
	end

	mcr_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.flush(fifo_flush),
		.in_valid(emit_valid),
		.in_ready(fifo_ready),
		.in_data({emit_eoi, emit_byte}),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data({out_eoi, out_byte})
	);

	assign cfg = cfg_reg;
	assign busy = st_reg != mcr_pkg::ST_IDLE;
	assign meas_start = start_reg;
	assign mem_wr = mem_wr_reg;
	assign mem_data = rdg_reg.real32;
	assign esr_dev_err = err_reg;
	assign query_err = qerr_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_measure_runs:
	assert property (load && cmd.op == mcr_pkg::CMD_MEASURE |=>
		st_reg != mcr_pkg::ST_IDLE) else $error("measure did not start");
	a_configure_idle:
	assert property (load && cmd.op == mcr_pkg::CMD_CONFIGURE |=>
		st_reg == mcr_pkg::ST_IDLE ##1 !meas_start)
		else $error("configure started a measurement");
	a_setup_defaults:
	assert property (load |=> cfg_reg.autozero &&
		!cfg_reg.offset_compensation_setting &&
		cfg_reg.trig_src == mcr_pkg::SRC_IMM &&
		cfg_reg.trig_count == 8'h01 && cfg_reg.samp_count == 8'h01)
		else $error("setup defaults wrong");
	a_aper_default:
	assert property (load && !cmd.res_given |=>
		cfg_reg.integration_line_cycles == 4'h1 && cfg_reg.aper_us ==
		($past(mains_50hz) ? 20'h04e20 : 20'h0413c))
		else $error("default aperture wrong");
	a_scan_mode:
	assert property (load |=> cfg_reg.scanning == $past(cmd.has_chan_list))
		else $error("scan mode wrong");
	a_arm_holds:
	assert property (st_reg == mcr_pkg::ST_WAIT_TRIG &&
		cfg_reg.trig_src != mcr_pkg::SRC_IMM && !trig_ext && !bus_trig |=>
		st_reg == mcr_pkg::ST_WAIT_TRIG) else $error("left arm untriggered");
	a_imm_start:
	assert property (st_reg == mcr_pkg::ST_WAIT_TRIG &&
		cfg_reg.trig_src == mcr_pkg::SRC_IMM && cfg_reg.delay_auto &&
		cfg_reg.func == mcr_pkg::FN_DCV |-> ##2 meas_start)
		else $error("immediate trigger did not measure");
	a_ovld_flag:
	assert property (st_reg == mcr_pkg::ST_SAMPLE && meas_done &&
		rdg.overload |=> esr_dev_err) else $error("overload not flagged");
	a_eoi_lf:
	assert property (out_valid && out_eoi |-> out_byte == mcr_pkg::CH_LF)
		else $error("end flag without line feed");
endmodule

`default_nettype wire

/* File: rtl/mcr_pkg.sv */
// Constants and types for the meter command and readout block
`default_nettype none

package mcr_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int DELAY_DC_MS = 0;
	localparam int DELAY_AC_MS = 500;
	localparam int DELAY_DC_CYC = DELAY_DC_MS * CLK_MHZ * 1000;
	localparam int DELAY_AC_CYC = DELAY_AC_MS * CLK_MHZ * 1000;
	localparam logic [19:0] APER_60HZ_US = 20'h0413c;
	localparam logic [19:0] APER_50HZ_US = 20'h04e20;
	localparam logic [3:0] LINE_CYC_RST = 4'h1;
	localparam logic [7:0] TRIG_COUNT_RST = 8'h01;
	localparam logic [7:0] SAMP_COUNT_RST = 8'h01;
	// ----------------------------------------
	// Output framing
	// ----------------------------------------
	localparam int FIFO_DEPTH = 16;
	localparam logic [3:0] ASCII_LEN = 4'hf;
	localparam logic [3:0] BYTES_REAL64 = 4'h8;
	localparam logic [3:0] BYTES_REAL32 = 4'h4;
	localparam logic [7:0] CH_HASH = 8'h23;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [119:0] ASCII_OVLD = 120'h202b392e393130303030452b303337;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {FN_DCV, FN_ACV, FN_RES,
		FN_FOUR_WIRE_RESISTANCE, FN_TEMP} mcr_func_e;
	typedef enum logic [1:0] {SRC_IMM, SRC_EXT, SRC_BUS} mcr_src_e;
	typedef enum logic [1:0] {FMT_ASCII, FMT_REAL64, FMT_REAL32} mcr_fmt_e;
	typedef enum logic [2:0] {CMD_NONE, CMD_MEASURE, CMD_CONFIGURE, CMD_SET,
		CMD_READ, CMD_INIT, CMD_BUS_TRIG} mcr_cmd_e;
	typedef enum logic [3:0] {PAR_RANGE, PAR_RES, PAR_APER, PAR_LINE_CYC,
		PAR_AUTOZERO, PAR_OFFSET_COMP, PAR_TRIG_SRC, PAR_TRIG_COUNT,
		PAR_DELAY, PAR_SAMP_COUNT, PAR_FORMAT} mcr_par_e;
	typedef enum logic [2:0] {ST_IDLE, ST_HEADER, ST_WAIT_TRIG, ST_DELAY,
		ST_SAMPLE, ST_EMIT} mcr_state_e;
	typedef struct packed {
		mcr_cmd_e op;
		mcr_func_e func;
		logic [7:0] range_code;
		logic range_auto;
		logic [7:0] res;
		logic res_given;
		logic has_chan_list;
		logic [5:0] chan_count;
		mcr_par_e par;
		logic [31:0] value;
	} mcr_cmd_s;
	typedef struct packed {
		mcr_func_e func;
		logic [7:0] range_code;
		logic range_auto;
		logic [7:0] res;
		logic [19:0] aper_us;
		logic [3:0] integration_line_cycles;
		logic autozero;
		logic offset_compensation_setting;
		mcr_src_e trig_src;
		logic [7:0] trig_count;
		logic [7:0] samp_count;
		logic delay_auto;
		logic [26:0] delay_cyc;
		mcr_fmt_e fmt;
		logic scanning;
		logic [5:0] chan_count;
	} mcr_cfg_s;
	typedef struct packed {
		logic [63:0] real64;
		logic [31:0] real32;
		logic [119:0] ascii;
		logic overload;
	} mcr_rdg_s;
	localparam mcr_cfg_s CFG_RST = '{func: FN_DCV, range_code: 8'h00,
		range_auto: 1'b1, res: 8'h00, aper_us: APER_60HZ_US,
		integration_line_cycles: LINE_CYC_RST, autozero: 1'b1,
		offset_compensation_setting: 1'b0, trig_src: SRC_IMM,
		trig_count: TRIG_COUNT_RST, samp_count: SAMP_COUNT_RST,
		delay_auto: 1'b1, delay_cyc: 27'h0000000, fmt: FMT_ASCII,
		scanning: 1'b0, chan_count: 6'h00};
endpackage

`default_nettype wire

/* File: tb/mcr_far_model.sv */
// Front end and host reader that sit around the meter block
`default_nettype none

module mcr_far_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic meas_start,
	input wire mcr_pkg::mcr_rdg_s rdg_val,
	input wire logic stall,
	output logic meas_done,
	output mcr_pkg::mcr_rdg_s rdg,
	output logic out_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt_reg;
	logic [7:0] lfsr_reg;
	// ----------------------------------------
	// Front end
	// ----------------------------------------
	// Junk outside the done pulse, so stale data never matches
	assign rdg = meas_done ? rdg_val : ~rdg_val;
	always_ff @(posedge clk)
	begin
		meas_done <= rst_n && cnt_reg == 3'h1;
		if (!rst_n)
			cnt_reg <= 3'h0;
		else if (meas_start)
			cnt_reg <= {1'b1, lfsr_reg[1:0]};
		else if (cnt_reg != 3'h0)
			cnt_reg <= cnt_reg - 3'h1;
	end
	// ----------------------------------------
	// Host reader
	// ----------------------------------------
	// Reads in random bursts; stall leaves an answer unread
	assign out_ready = !stall && lfsr_reg[0];
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			lfsr_reg <= 8'h5a;
		else
			lfsr_reg <= {lfsr_reg[6:0], ^(lfsr_reg & 8'hb8)};
	end
endmodule

`default_nettype wire

/* File: tb/meter_config_trigger_readout_tb.sv */
// Self-checking bench for the meter command and readout block
`default_nettype none

module meter_config_trigger_readout_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, mains_50hz = 1'b0, cmd_valid = 1'b0;
	logic trig_ext = 1'b0, esr_clear = 1'b0, stall = 1'b0;
	logic cmd_ready, ocomp_apply, busy, meas_start, meas_done, out_valid;
	logic out_ready, out_eoi, mem_wr, esr_dev_err, query_err;
	logic [7:0] out_byte;
	logic [31:0] mem_data, t, seed = 32'h34;
	mcr_pkg::mcr_cmd_s cmd = '0;
	mcr_pkg::mcr_cfg_s cfg;
	mcr_pkg::mcr_rdg_s rdg, rdg_val = '0;
	int errors = 0, checks = 0, n_mem = 0, n_qe = 0, n_st = 0, i, n;
	logic [8:0] got[$], exp[$];
	mcr_meter_top #(.DELAY_AC_CYC(20)) uut (.clk(clk), .rst_n(rst_n),
		.mains_50hz(mains_50hz), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd(cmd), .trig_ext(trig_ext), .cfg(cfg), .ocomp_apply(ocomp_apply),
		.busy(busy), .meas_start(meas_start), .meas_done(meas_done),
		.rdg(rdg), .out_valid(out_valid), .out_ready(out_ready),
		.out_byte(out_byte), .out_eoi(out_eoi), .mem_wr(mem_wr),
		.mem_data(mem_data), .esr_dev_err(esr_dev_err),
		.esr_clear(esr_clear), .query_err(query_err));
	mcr_far_model far (.clk(clk), .rst_n(rst_n), .meas_start(meas_start),
		.rdg_val(rdg_val), .stall(stall), .meas_done(meas_done), .rdg(rdg),
		.out_ready(out_ready));
	always #2 clk = ~clk;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string w, input logic [127:0] e,
		input logic [127:0] g);
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic hang();
		errors++;
		$display("wrong value wait expected done seen timeout");
		stop_test();
	endtask
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic tk(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task automatic newr(input logic ov);
		rdg_val.real64 = {rnd(), rnd()};
		rdg_val.real32 = rnd();
		rdg_val.ascii = 120'({rnd(), rnd(), rnd(), rnd()});
		rdg_val.overload = ov;
	endtask
	// Idle edge first, so valid never drops and rises in one step
	// Request held until the edge that sees ready
	task automatic iss(input mcr_pkg::mcr_cmd_e op,
		input logic [31:0] v = 32'h100, input logic [5:0] ch = 6'h00,
		input mcr_pkg::mcr_func_e f = mcr_pkg::FN_DCV,
		input mcr_pkg::mcr_par_e p = mcr_pkg::PAR_RANGE);
		tk(1);
		cmd = '{op: op, func: f, range_code: v[7:0], range_auto: v[8],
			res: 8'h00, res_given: 1'b0, has_chan_list: ch != 6'h00,
			chan_count: ch, par: p, value: v};
		cmd_valid = 1'b1;
		for (int k = 0; cmd_ready !== 1'b1; k++)
		begin
			if (k > 400)
				hang();
			tk(1);
		end
		tk(1);
		cmd_valid = 1'b0;
	endtask
	task automatic st(input mcr_pkg::mcr_par_e p, input logic [31:0] v);
		iss(mcr_pkg::CMD_SET, v, 6'h00, mcr_pkg::FN_DCV, p);
	endtask
	// Host waits for the whole answer before the next command
	task automatic drn(input string w);
		for (int k = 0; busy !== 1'b0 || out_valid !== 1'b0; k++)
		begin
			if (k > 4000)
				hang();
			tk(1);
		end
		tk(2);
		chk({w, " size"}, exp.size(), got.size());
		foreach (exp[k])
			chk(w, exp[k], got[k]);
		got.delete();
		exp.delete();
		$display("test %s done", w);
	endtask
	function automatic void xp(input mcr_pkg::mcr_fmt_e f, input int r,
		input logic [119:0] a);
		int b = f == mcr_pkg::FMT_REAL64 ? 8 : 4;
		int tot = r * b;
		int nd = tot < 10 ? 1 : tot < 100 ? 2 : 3;
		logic [119:0] s = f == mcr_pkg::FMT_ASCII ? a :
			f == mcr_pkg::FMT_REAL64 ? {rdg_val.real64, 56'h0} :
			{rdg_val.real32, 88'h0};
		if (f == mcr_pkg::FMT_ASCII)
			b = 15;
		else
		begin
			exp.push_back({1'b0, mcr_pkg::CH_HASH});
			exp.push_back(9'(48 + nd));
			for (int d = nd - 1; d >= 0; d--)
				exp.push_back(9'(48 + tot / 10 ** d % 10));
		end
		for (int q = 0; q < r * b; q++)
		begin
			exp.push_back({1'b0, s[119 - 8 * (q % b) -: 8]});
			if (b == 15 && q % 15 == 14 && q < r * 15 - 1)
				exp.push_back({1'b0, mcr_pkg::CH_COMMA});
		end
		exp.push_back({1'b1, mcr_pkg::CH_LF});
	endfunction
	always @(posedge clk)
	begin
		if (out_valid === 1'b1 && out_ready === 1'b1)
			got.push_back({out_eoi, out_byte});
		if (meas_start === 1'b1)
			n_st++;
		if (query_err === 1'b1)
			n_qe++;
		if (mem_wr === 1'b1)
		begin
			n_mem++;
			chk("mem_data", rdg_val.real32, mem_data);
		end
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		tk(20);
		rst_n = 1'b1;
		chk("aper", 20'h0413c, cfg.aper_us);
		chk("plc", 4'h1, cfg.integration_line_cycles);
		chk("azero", 1'b1, cfg.autozero);
		chk("ocomp", 1'b0, cfg.offset_compensation_setting);
		chk("src", mcr_pkg::SRC_IMM, cfg.trig_src);
		chk("tcount", 8'h01, cfg.trig_count);
		chk("scount", 8'h01, cfg.samp_count);
		chk("fmt", mcr_pkg::FMT_ASCII, cfg.fmt);
		$display("test reset done");
		mains_50hz = 1'b1;
		iss(mcr_pkg::CMD_CONFIGURE, 32'h37, 6'h03, mcr_pkg::FN_RES);
		tk(30);
		chk("start", 0, n_st);
		chk("aper50", 20'h04e20, cfg.aper_us);
		chk("range", 9'h037, {cfg.range_auto, cfg.range_code});
		chk("res", 8'h38, cfg.res);
		chk("scan", 7'h43, {cfg.scanning, cfg.chan_count});
		st(mcr_pkg::PAR_AUTOZERO, 32'h0);
		chk("az_set", 1'b0, cfg.autozero);
		st(mcr_pkg::PAR_RES, 32'h5a);
		chk("res_set", 8'h5a, cfg.res);
		st(mcr_pkg::PAR_OFFSET_COMP, 32'h1);
		st(mcr_pkg::PAR_TRIG_COUNT, 32'h2);
		chk("oc_apply", 1'b1, ocomp_apply);
		newr(1'b0);
		iss(mcr_pkg::CMD_READ);
		xp(mcr_pkg::FMT_ASCII, 6, rdg_val.ascii);
		drn("read scan");
		mains_50hz = 1'b0;
		for (i = 0; i < 3; i++)
		begin
			st(mcr_pkg::PAR_FORMAT, i == 0 ? 32'h1 : 32'h2);
			newr(1'b0);
			iss(mcr_pkg::CMD_MEASURE, 32'h100, i == 2 ? 6'h03 : 6'h00);
			chk("auto", 1'b1, cfg.range_auto);
			chk("oc", 2'b00, {cfg.offset_compensation_setting,
				ocomp_apply});
			chk("aper60", 20'h0413c, cfg.aper_us);
			chk("az", 1'b1, cfg.autozero);
			xp(i == 0 ? mcr_pkg::FMT_REAL64 : mcr_pkg::FMT_REAL32,
				i == 2 ? 3 : 1, 120'h0);
			drn("binary");
		end
		iss(mcr_pkg::CMD_CONFIGURE);
		for (i = 1; i < 3; i++)
		begin
			st(mcr_pkg::PAR_TRIG_SRC, i);
			n = n_st;
			iss(mcr_pkg::CMD_READ);
			tk(40);
			chk("armed", {1'b1, 32'(n)}, {busy, 32'(n_st)});
			if (i == 1)
				trig_ext = 1'b1;
			else
				iss(mcr_pkg::CMD_BUS_TRIG);
			xp(mcr_pkg::FMT_REAL32, 1, 120'h0);
			drn("source");
			trig_ext = 1'b0;
		end
		st(mcr_pkg::PAR_TRIG_SRC, 32'h0);
		st(mcr_pkg::PAR_SAMP_COUNT, 32'h3);
		newr(1'b0);
		n = n_mem;
		iss(mcr_pkg::CMD_INIT);
		drn("init");
		chk("writes", 3, n_mem - n);
		for (i = 0; i < 2; i++)
		begin
			n = n_st;
			iss(mcr_pkg::CMD_MEASURE, 32'h100, 6'h00,
				i ? mcr_pkg::FN_ACV : mcr_pkg::FN_DCV);
			for (t = 0; n_st == n && t < 100; t++)
				tk(1);
			// Three header bytes and three cycles to start, plus delay
			chk("delay", i ? 32'h1a : 32'h6, t);
			xp(mcr_pkg::FMT_REAL32, 1, 120'h0);
			drn("delay");
		end
		st(mcr_pkg::PAR_FORMAT, 32'h0);
		newr(1'b1);
		iss(mcr_pkg::CMD_MEASURE, 32'h100, 6'h00, mcr_pkg::FN_TEMP);
		xp(mcr_pkg::FMT_ASCII, 1, 120'h202b392e393130303030452b303337);
		drn("overload");
		chk("dev_err", 1'b1, esr_dev_err);
		chk("no_msg", 0, n_qe);
		esr_clear = 1'b1;
		tk(1);
		esr_clear = 1'b0;
		tk(1);
		chk("dev_clr", 1'b0, esr_dev_err);
		stall = 1'b1;
		iss(mcr_pkg::CMD_MEASURE);
		tk(60);
		iss(mcr_pkg::CMD_CONFIGURE);
		tk(3);
		chk("qerr", 1, n_qe);
		chk("flushed", 1'b0, out_valid);
		stall = 1'b0;
		$display("test query done");
		stop_test();
	end
endmodule

`default_nettype wire
